// ### src/cpw_map.svh
// Register map and reset values of the pulse-width block
// Assumes a 32-bit classic Wishbone slave with word-aligned registers
`ifndef CPW_MAP_SVH
`define CPW_MAP_SVH
`define CPW_ADR_CTRL     6'h00
`define CPW_ADR_DUTY     6'h04
`define CPW_ADR_SHADOW   6'h08
`define CPW_ADR_PERIOD   6'h0c
`define CPW_ADR_PIN      6'h10
`define CPW_ADR_TIMER    6'h14
`define CPW_CTRL_MODE_LO 0
`define CPW_CTRL_MODE_HI 3
`define CPW_CTRL_DLO_LO  4
`define CPW_CTRL_DLO_HI  5
`define CPW_CTRL_RST     8'h00
`define CPW_DUTY_RST     8'h00
`define CPW_PERIOD_RST   8'hff
`define CPW_PIN_DIR_RST  1'b1
`define CPW_MODE_PWM     4'hc
`define CPW_PRE_1        2'h0
`define CPW_PRE_4        2'h1
`endif

// ### src/cpw_pkg.sv
// Types shared by the pulse-width block
// Assumes the map header is included alongside
package cpw_pkg;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [5:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } cpw_wb_req_t;
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } cpw_wb_rsp_t;
  typedef struct packed {
    logic o;
    logic oe_n;
  } cpw_pin_t;
endpackage

// ### src/cpw_top.sv
// Pulse-width output of a capture/compare module with its period timer
// Assumes a classic Wishbone master and an external prescale select
//
// The register addresses and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`include "cpw_map.svh"

////////////////////////////////////////////////////////////////////////
// Operation
// - Pulse output with ten-bit duty resolution
// - Pin driven only when direction selects output
// - Zero control write forces module latch low
// - Period is (match+1) x4 oscillator x prescale
// - Timer clears after equalling the match value
// - Restart sets pin high unless duty zero
// - Restart copies written duty into shadow
// - Duty is register bits plus control 5:4
// - High time is duty x oscillator x prescale
// - Duty writes anytime, take effect next period
// - Shadow readable, software writes ignored in mode
module cpw_top #(
  parameter int PRE_W = 4
) (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst,
  input  wire cpw_pkg::cpw_wb_req_t i_wb,
  input  wire logic [1:0]           i_prescale,
  output logic                      o_wb_ack,
  output logic [31:0]               o_wb_dat,
  output logic                      o_pulse_output_pin,
  output logic                      o_pulse_output_pin_oe_n
);
  import cpw_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Behaviour notes
  // Bus: request taken with ack low, ack one cycle later
  // Bus: writes land on the edge where ack is sampled high
  // Bus: reads are registered, data valid only with ack
  // Bus: byte lane 0 qualifies every write
  // Bus: cyc and stb must fall between two requests
  // Timer: runs only in pulse mode, held at zero otherwise
  // Timer: prescale tick every one, four or sixteen cycles
  // Timer: sub-counter adds two fine bits per timer step
  // Timer: increment on the fourth tick of the sub-counter
  // Period: restart on the increment where timer equals match
  // Period: length is (match+1) x 4 x prescale cycles
  // Duty: written value copied to shadow only at restart
  // Duty: shadow read-only while pulse mode is on
  // Duty: outside pulse mode a shadow write loads the top bits
  // Output: set at restart unless the new duty is zero
  // Output: cleared when the fine count steps onto the shadow
  // Output: never cleared when duty reaches a full period
  // Output: leaving pulse mode drops the latch at once
  // Pin: driven only with the direction bit at output
  // Pin: updates on the same edge as the latch
  // Hazard: prescale change mid-period stretches that period
  // Hazard: match value below timer waits a full wrap
  // Hazard: low duty bits share the control register write
  // Hazard: a control write that leaves pulse mode clears counters and latch

  ////////////////////////////////////////////////////////////////////
  // Register map, byte offsets on the bus
  // 0x00 control: mode in [3:0], low duty bits in [5:4]
  // 0x04 duty: eight high duty bits
  // 0x08 shadow: ten-bit duty in use, read-only in pulse mode
  // 0x0c period match: timer end value
  // 0x10 direction: bit 0, set releases the pin
  // 0x14 timer: current period timer count, read-only
  // Other offsets read zero and ignore writes

  ////////////////////////////////////////////////////////////////////
  // Timing walk at prescale one, match m, duty d
  // Edge 0: restart, timer and sub clear, latch set
  // Edge k: fine count steps from k-1 to k on each tick
  // Edge d: fine count reaches d, latch cleared
  // Edge 4(m+1): next restart, pin on the same edge as latch

  ////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]       module_control_register;
  logic [7:0]       duty_write_register;
  logic [9:0]       duty_shadow_register;
  logic [7:0]       period_match_value;
  logic             pin_direction_bit;
  logic [7:0]       period_timer_count;
  logic [1:0]       sub_count;
  logic [PRE_W-1:0] pre_count;
  logic             out_latch;

  ////////////////////////////////////////////////////////////////////
  // Bus decode
  wire   acc     = i_wb.cyc & i_wb.stb & ~o_wb_ack;
  // Write commits on the edge where the master sees ack
  wire   commit  = i_wb.cyc & i_wb.stb & o_wb_ack;
  wire   wr      = commit & i_wb.we & i_wb.sel[0];
  wire   wr_ctrl = wr & (i_wb.adr == `CPW_ADR_CTRL);
  wire   wr_duty = wr & (i_wb.adr == `CPW_ADR_DUTY);
  wire   wr_shd  = wr & (i_wb.adr == `CPW_ADR_SHADOW);
  wire   wr_per  = wr & (i_wb.adr == `CPW_ADR_PERIOD);
  wire   wr_pin  = wr & (i_wb.adr == `CPW_ADR_PIN);
  wire   pwm_on  = module_control_register[`CPW_CTRL_MODE_HI:
                   `CPW_CTRL_MODE_LO] == `CPW_MODE_PWM;
  // Written duty value, eight high plus two low bits
  wire [9:0] duty_written = {duty_write_register,
    module_control_register[`CPW_CTRL_DLO_HI:`CPW_CTRL_DLO_LO]};

  logic [31:0] rd_mux;
  always_comb begin
    case (i_wb.adr)
      `CPW_ADR_CTRL:   rd_mux = {24'h0, module_control_register};
      `CPW_ADR_DUTY:   rd_mux = {24'h0, duty_write_register};
      `CPW_ADR_SHADOW: rd_mux = {22'h0, duty_shadow_register};
      `CPW_ADR_PERIOD: rd_mux = {24'h0, period_match_value};
      `CPW_ADR_PIN:    rd_mux = {31'h0, pin_direction_bit};
      `CPW_ADR_TIMER:  rd_mux = {24'h0, period_timer_count};
      default:         rd_mux = 32'h0;
    endcase
  end

  // Read data held only for the ack cycle
  wire [31:0] next_rd_dat = acc ? rd_mux : 32'h0;

  // Ack one cycle after request, dropped the next
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst)
      o_wb_ack <= 1'b0;
    else
      o_wb_ack <= acc;
  end

  // Read data register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst)
      o_wb_dat <= 32'h0;
    else
      o_wb_dat <= next_rd_dat;
  end

  ////////////////////////////////////////////////////////////////////
  // Time base
  logic [PRE_W-1:0] pre_max;
  always_comb begin
    case (i_prescale)
      `CPW_PRE_1: pre_max = PRE_W'(0);
      `CPW_PRE_4: pre_max = PRE_W'(3);
      default:    pre_max = PRE_W'(15);
    endcase
  end
  wire tick     = pwm_on & (pre_count == pre_max);
  wire inc      = tick & (sub_count == 2'h3); // four prescaled ticks
  wire restart  = inc & (period_timer_count == period_match_value);
  wire [9:0] fine      = {period_timer_count, sub_count};
  // Fine count after this tick; high lasts exactly duty ticks
  wire [9:0] next_fine = fine + 10'h1;
  // Restart outranks a match, so full duty stays high
  wire hit      = tick & (next_fine == duty_shadow_register);

  // Next prescaler, sub-counter and timer values
  logic [PRE_W-1:0] next_pre_count;
  logic [1:0]       next_sub_count;
  logic [7:0]       next_timer;
  always_comb begin
    next_pre_count = pre_count;
    next_sub_count = sub_count;
    next_timer     = period_timer_count;
    if (!pwm_on) begin
      next_pre_count = '0;
      next_sub_count = 2'h0;
      next_timer     = 8'h0;
    end else begin
      if (tick)
        next_pre_count = '0;
      else
        next_pre_count = pre_count + PRE_W'(1);
      if (tick)
        next_sub_count = sub_count + 2'h1;
      if (restart)
        next_timer = 8'h0;
      else if (inc)
        next_timer = period_timer_count + 8'h1;
    end
  end

  // Prescaler, four-phase sub-counter and period timer
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_count          <= '0;
      sub_count          <= 2'h0;
      period_timer_count <= 8'h0;
    end else begin
      pre_count          <= next_pre_count;
      sub_count          <= next_sub_count;
      period_timer_count <= next_timer;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Software registers

  // Control register: mode and low duty bits
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst)
      module_control_register <= `CPW_CTRL_RST;
    else if (wr_ctrl)
      module_control_register <= i_wb.dat[7:0];
  end

  // Duty register: eight high duty bits
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst)
      duty_write_register <= `CPW_DUTY_RST;
    else if (wr_duty)
      duty_write_register <= i_wb.dat[7:0];
  end

  // Period match register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst)
      period_match_value <= `CPW_PERIOD_RST;
    else if (wr_per)
      period_match_value <= i_wb.dat[7:0];
  end

  // Direction bit, set means input
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst)
      pin_direction_bit <= `CPW_PIN_DIR_RST;
    else if (wr_pin)
      pin_direction_bit <= i_wb.dat[0];
  end

  // Next shadow: restart load wins over a bus write
  logic [9:0] next_shadow;
  always_comb begin
    next_shadow = duty_shadow_register;
    if (restart)
      next_shadow = duty_written;
    else if (wr_shd && !pwm_on)
      next_shadow = {i_wb.dat[7:0], 2'h0};
  end

  // Duty shadow register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst)
      duty_shadow_register <= 10'h0;
    else
      duty_shadow_register <= next_shadow;
  end

  ////////////////////////////////////////////////////////////////////
  // Output latch
  logic next_out;
  always_comb begin
    next_out = out_latch;
    if (!pwm_on)
      next_out = 1'b0;
    else if (restart)
      next_out = (duty_written != 10'h0);
    else if (hit)
      next_out = 1'b0;
  end

  // Pin value and enable ahead of the output flops
  wire next_pin  = next_out & ~pin_direction_bit;
  wire next_oe_n = pin_direction_bit;

  // Module output latch
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst)
      out_latch <= 1'b0;
    else
      out_latch <= next_out;
  end

  // Pin flops, released while direction is input
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pulse_output_pin      <= 1'b0;
      o_pulse_output_pin_oe_n <= 1'b1;
    end else begin
      o_pulse_output_pin      <= next_pin;
      o_pulse_output_pin_oe_n <= next_oe_n;
    end
  end
endmodule

// ### tb/cpw_properties.sv
// Port checker for cpw_top
// Bound from the bench top; one clock domain
`timescale 1ns/1ps
module cpw_properties #(parameter int PRE_W = 4) (
  input wire logic                 i_ref_clk,
  input wire logic                 i_rst,
  input wire cpw_pkg::cpw_wb_req_t i_wb,
  input wire logic [1:0]           i_prescale,
  input wire logic                 o_wb_ack,
  input wire logic [31:0]          o_wb_dat,
  input wire logic                 o_pulse_output_pin,
  input wire logic                 o_pulse_output_pin_oe_n
);
  import cpw_pkg::*;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // Request taken, control cleared
  sequence s_req; i_wb.cyc && i_wb.stb && !o_wb_ack; endsequence
  sequence s_clr; o_wb_ack && i_wb.we && i_wb.sel[0] && i_wb.adr == 6'h00
    && i_wb.dat[7:0] == 8'h00; endsequence
  AST_ACK_NEXT: assert property (s_req |=> o_wb_ack) else $error("no ack");
  AST_ACK_ONE: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack");
  AST_ACK_CAUSE: assert property (o_wb_ack |-> $past(i_wb.cyc && i_wb.stb))
    else $error("stray ack");
  AST_DAT_IDLE: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("data idle");
  AST_DAT_WIDTH: assert property (
    o_wb_ack |-> o_wb_dat[31:10] == 22'h0) else $error("data width");
  AST_PIN_DIR: assert property (
    o_pulse_output_pin_oe_n |-> !o_pulse_output_pin) else $error("pin");
  AST_DIR_WRITE: assert property (
    !$stable(o_pulse_output_pin_oe_n) |-> $past(o_wb_ack) ||
    $past(o_wb_ack, 2)) else $error("oe change");
  AST_CTRL_CLR: assert property (
    s_clr |-> ##[1:3] !o_pulse_output_pin [*4]) else $error("clear");
endmodule

// ### tb/cpw_pin_model.sv
// Receiver on the pulse pin: measures period and high time
// Assumes a pull-down on the pin while it is released
`timescale 1ns/1ps
module cpw_pin_model (
  input  wire logic i_ref_clk,
  input  wire logic i_pin,
  input  wire logic i_oe_n,
  output int        o_high,
  output int        o_period
);
  logic lvl, prev;
  int   cnt, hi;
  // Pull-down when released
  assign lvl = !i_oe_n && i_pin;
  // Cycles between rises and while high
  always_ff @(posedge i_ref_clk) begin
    prev <= lvl;
    cnt  <= (lvl && !prev) ? 1 : cnt + 1;
    hi   <= (lvl && !prev) ? 1 : hi + int'(lvl);
    if (lvl && !prev) o_period <= cnt;
    if (!lvl && prev) o_high <= hi;
  end
endmodule

// ### tb/cpw_tb_top.sv
// Bench top for cpw_top: bus tasks, scenarios, verdict
// Assumes model and checker compiled before
`timescale 1ns/1ps
module cpw_tb_top;
  import cpw_pkg::*;
  logic        clk, rst, ack, pin, oe_n;
  logic [1:0]  pre;
  logic [31:0] dat, q;
  cpw_wb_req_t wb;
  int high, per, num_errors, samples_checked, cyc_n, n;
  cpw_top dut (.i_ref_clk(clk), .i_rst(rst), .i_wb(wb), .i_prescale(pre),
    .o_wb_ack(ack), .o_wb_dat(dat), .o_pulse_output_pin(pin),
    .o_pulse_output_pin_oe_n(oe_n));
  cpw_pin_model pm (.i_ref_clk(clk), .i_pin(pin), .i_oe_n(oe_n),
    .o_high(high), .o_period(per));
  task automatic w(input int k);
    repeat (k) @(posedge clk);
  endtask
  // One classic cycle, held until ack
  task automatic bus(input logic we, input logic [5:0] a,
                     input logic [7:0] d);
    wb <= {2'b11, we, a, 4'h1, 24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = dat;
    wb <= '0;
    w(1);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, s);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic rises(input int k);
    repeat (k) @(posedge pin);
    w(2);
  endtask
  // Reset values and an unmapped read
  task automatic t_regs;
    bus(0, 6'h0c, 0); chk("period", 32'hff, q);
    bus(0, 6'h10, 0); chk("dir", 32'h1, q);
    bus(0, 6'h18, 0); chk("unmapped", 32'h0, q);
  endtask
  // Period and high time at two prescales
  task automatic t_period;
    bus(1, 6'h0c, 8'h04); bus(1, 6'h04, 8'h03);
    bus(1, 6'h00, 8'h2c); bus(1, 6'h10, 8'h00);
    for (int p = 0; p < 2; p++) begin
      pre <= p[1:0];
      rises(3);
      chk("period", 20 << 2 * p, per);
      chk("high", 14 << 2 * p, high);
    end
    pre <= 2'h0;
    rises(2);
  endtask
  // Duty written mid-period lands at restart
  task automatic t_shadow;
    rises(1);
    bus(1, 6'h04, 8'h01); bus(1, 6'h08, 8'h55);
    bus(0, 6'h08, 0); chk("shadow", 32'h0e, q);
    rises(1); bus(0, 6'h08, 0); chk("shadow", 32'h06, q);
    rises(2); chk("high", 6, high);
  endtask
  // Zero and full duty, direction, clear
  task automatic t_level;
    for (int k = 0; k < 2; k++) begin
      bus(1, 6'h04, k ? 8'hff : 8'h00); bus(1, 6'h00, k ? 8'h3c : 8'h0c);
      w(50);
      n = 0;
      repeat (40) begin w(1); n += int'(pin === 1'b1); end
      chk("high count", k * 40, n);
    end
    bus(1, 6'h10, 8'h01); w(3); chk("released", 0, pin);
    bus(1, 6'h10, 8'h00); w(3); chk("driven", 1, pin);
    bus(1, 6'h00, 8'h00); w(3); chk("cleared", 0, pin);
    bus(0, 6'h14, 0); chk("timer held", 0, q);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Clock, timeout, main sequence
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin num_errors++; final_report; end
  end
  initial begin
    rst = 1; wb = '0; pre = 0;
    w(16);
    rst <= 0;
    w(1);
    t_regs; t_period; t_shadow; t_level;
    final_report;
  end
endmodule
bind cpw_top cpw_properties #(.PRE_W(PRE_W)) u_props (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_wb(i_wb),
  .i_prescale(i_prescale), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
  .o_pulse_output_pin(o_pulse_output_pin),
  .o_pulse_output_pin_oe_n(o_pulse_output_pin_oe_n));
